// ===== tb_tomd_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_tomd_top;
  logic                  clock = 1'b0;
  logic                  resetn, m_valid, entry_valid, all_invalid_response, peer_holds_shared;
  logic                  peer_forwarded_modified, prefetch_hit, match_any, match_a, match_b;
  logic                  replacement_update, launch_ownership_read, launch_code_read, launch_data_read;
  logic                  commit_before_data, byte_mask_used;
  logic [3:0]            m_side;
  logic [8:0]            flags;
  logic [11:0]           m_opcode, entry_opcode, filter_opcode_match_field_a, filter_opcode_match_field_b;
  tomd_pkg::tomd_queue_t m_queue, entry_queue;
  tomd_pkg::tomd_kind_t  entry_kind;
  tomd_pkg::tomd_state_t granted_state;
  int                    n_errors = 0;
  int                    comparisons = 0;
  // every listed value, class order core, probe, remote, writeback
  logic [11:0] tbl [32] = '{12'h245, 12'h246, 12'h247, 12'h248, 12'h258, 12'h259, 12'h25A, 12'h279,
    12'h27A, 12'h27B, 12'h27E, 12'h27F, 12'h180, 12'h181, 12'h182, 12'h183, 12'h184, 12'h185, 12'h080,
    12'h081, 12'h082, 12'h083, 12'h084, 12'h085, 12'h086, 12'h087, 12'h08C, 12'h000, 12'h001, 12'h002,
    12'h003, 12'h004};
  // unlisted pairs {class, value}
  logic [13:0] bad [6] = '{14'h0244, 14'h0180, 14'h1186, 14'h208F, 14'h2245, 14'h3005};

  assign flags = {match_any, match_a, match_b, replacement_update, launch_ownership_read, launch_code_read,
    launch_data_read, commit_before_data, byte_mask_used};

  always #12.5 clock = ~clock;

  tomd_tracker_model i_tomd_tracker_model (.*);
  tomd_top i_tomd_top (.*);

  task chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task put(input logic v, input logic [1:0] q, input logic [11:0] o, input logic [3:0] s);
    m_valid <= v;
    m_queue <= tomd_pkg::tomd_queue_t'(q);
    m_opcode <= o;
    m_side <= s;
  endtask

  // one entry through the tracker, field a equal to it; state 7 means not judged
  task shot(input logic v, input logic [1:0] q, input logic [11:0] o, input logic [3:0] s,
            input logic [5:0] k, input logic [8:0] fl, input logic [2:0] st, input logic [11:0] fb = 12'hFFF);
    @(posedge clock);
    put(v, q, o, s);
    @(posedge clock);
    put(1'b0, 2'h0, 12'h000, 4'h0);
    filter_opcode_match_field_a <= o;
    filter_opcode_match_field_b <= fb;
    @(posedge clock);
    #1;
    chk({6'h00, entry_kind}, {6'h00, k});
    chk({3'h0, flags}, {3'h0, fl});
    if (st != 3'h7) chk({9'h000, granted_state}, {9'h000, st});
  endtask

  // back-to-back listed values, matched by one field only
  task t_stream(input logic use_b);
    for (int i = 0; i < 34; i++) begin
      @(posedge clock);
      put(i < 32, i < 12 ? 2'h0 : i < 18 ? 2'h1 : i < 27 ? 2'h2 : 2'h3, tbl[i % 32], 4'h0);
      if (i >= 1 && i <= 32) begin
        filter_opcode_match_field_a <= use_b ? 12'hFFF : tbl[i - 1];
        filter_opcode_match_field_b <= use_b ? tbl[i - 1] : 12'hFFF;
      end
      #1;
      if (i >= 2) begin
        chk({6'h00, entry_kind}, 12'(i - 1));
        chk({9'h000, flags[8:6]}, {9'h000, 1'b1, !use_b, use_b});
      end
    end
  endtask

  task t_refuse;
    for (int i = 0; i < 6; i++) shot(1'b1, bad[i][13:12], bad[i][11:0], 4'hF, 6'h00, 9'h000, 3'h0, bad[i][11:0]);
    shot(1'b0, 2'h0, 12'h245, 4'hF, 6'h00, 9'h000, 3'h0, 12'h245);
  endtask

  task t_side;
    shot(1'b1, 2'h0, 12'h245, 4'h0, 6'h01, 9'h1C0, 3'h3, 12'h245);
    shot(1'b1, 2'h0, 12'h246, 4'h0, 6'h02, 9'h180, 3'h1);
    shot(1'b1, 2'h0, 12'h247, 4'h0, 6'h03, 9'h180, 3'h3);
    shot(1'b1, 2'h0, 12'h248, 4'h0, 6'h04, 9'h180, 3'h3);
    shot(1'b1, 2'h0, 12'h258, 4'h1, 6'h05, 9'h1A0, 3'h7);
    shot(1'b1, 2'h0, 12'h258, 4'h0, 6'h05, 9'h190, 3'h7);
    shot(1'b1, 2'h0, 12'h259, 4'h0, 6'h06, 9'h188, 3'h7);
    shot(1'b1, 2'h0, 12'h25A, 4'h0, 6'h07, 9'h184, 3'h7);
    shot(1'b1, 2'h0, 12'h25A, 4'h1, 6'h07, 9'h1A0, 3'h7);
    shot(1'b1, 2'h1, 12'h182, 4'h8, 6'h0F, 9'h180, 3'h3);
    shot(1'b1, 2'h1, 12'h182, 4'h0, 6'h0F, 9'h180, 3'h2);
    shot(1'b1, 2'h2, 12'h080, 4'h0, 6'h13, 9'h180, 3'h1);
    shot(1'b1, 2'h2, 12'h082, 4'h4, 6'h15, 9'h180, 3'h2);
    shot(1'b1, 2'h2, 12'h082, 4'h0, 6'h15, 9'h180, 3'h3);
    shot(1'b1, 2'h2, 12'h083, 4'h2, 6'h16, 9'h180, 3'h4);
    shot(1'b1, 2'h2, 12'h084, 4'h2, 6'h17, 9'h180, 3'h4);
    shot(1'b1, 2'h2, 12'h084, 4'h0, 6'h17, 9'h180, 3'h3);
    shot(1'b1, 2'h2, 12'h08C, 4'h0, 6'h1B, 9'h182, 3'h3);
    shot(1'b1, 2'h3, 12'h000, 4'h0, 6'h1C, 9'h180, 3'h1);
    shot(1'b1, 2'h3, 12'h001, 4'h0, 6'h1D, 9'h180, 3'h2);
    shot(1'b1, 2'h3, 12'h002, 4'h0, 6'h1E, 9'h180, 3'h3);
    shot(1'b1, 2'h3, 12'h003, 4'h0, 6'h1F, 9'h180, 3'h5);
    shot(1'b1, 2'h3, 12'h004, 4'h0, 6'h20, 9'h181, 3'h1);
  endtask

  task wrap_up;
    $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // cuts a hang after about ten times the expected run
  initial begin
    #50000;
    n_errors++;
    wrap_up();
  end

  initial begin
    resetn = 1'b0;
    put(1'b0, 2'h0, 12'h000, 4'h0);
    filter_opcode_match_field_a = 12'h000;
    filter_opcode_match_field_b = 12'h000;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    t_stream(1'b0);
    t_stream(1'b1);
    t_refuse();
    t_side();
    wrap_up();
  end
endmodule // tb_tomd_top

`default_nettype wire

// ===== tomd_classify.sv
`timescale 1ns/1ps
`default_nettype none

// combinational opcode classifier; unlisted value for a class yields none
module tomd_classify (
  tomd_class_if.classifier cls
);

  // class and opcode must agree exactly
  always_comb begin
    cls.kind = tomd_pkg::TOMD_K_NONE;
    unique case (cls.queue)
      tomd_pkg::TOMD_Q_CORE: begin
        unique case (cls.opcode)
          tomd_pkg::OPC_WRITEBACK_MODIFIED_KEEP_EXCLUSIVE: cls.kind = tomd_pkg::TOMD_K_WB_M_E;
          tomd_pkg::OPC_CLEAN_WRITEBACK_DROP:              cls.kind = tomd_pkg::TOMD_K_CWB_DROP;
          tomd_pkg::OPC_CLEAN_WRITEBACK_KEEP:              cls.kind = tomd_pkg::TOMD_K_CWB_KEEP;
          tomd_pkg::OPC_INVALIDATE_FOR_OWNERSHIP:          cls.kind = tomd_pkg::TOMD_K_INV_OWN;
          tomd_pkg::OPC_PREFETCH_OWNERSHIP_READ:           cls.kind = tomd_pkg::TOMD_K_PF_OWN;
          tomd_pkg::OPC_PREFETCH_CODE_READ:                cls.kind = tomd_pkg::TOMD_K_PF_CODE;
          tomd_pkg::OPC_PREFETCH_DATA_READ:                cls.kind = tomd_pkg::TOMD_K_PF_DATA;
          tomd_pkg::OPC_LOGICAL_INTERRUPT:                 cls.kind = tomd_pkg::TOMD_K_INT_LOG;
          tomd_pkg::OPC_PHYSICAL_INTERRUPT:                cls.kind = tomd_pkg::TOMD_K_INT_PHY;
          tomd_pkg::OPC_INTERRUPT_PRIORITY_UPDATE:         cls.kind = tomd_pkg::TOMD_K_INT_PRI;
          tomd_pkg::OPC_SPLIT_LOCK_START:                  cls.kind = tomd_pkg::TOMD_K_SPLITLK;
          tomd_pkg::OPC_LOCK_START:                        cls.kind = tomd_pkg::TOMD_K_LOCK;
          default:                                         cls.kind = tomd_pkg::TOMD_K_NONE;
        endcase
      end
      tomd_pkg::TOMD_Q_PROBE: begin
        unique case (cls.opcode)
          tomd_pkg::OPC_SNAPSHOT_SNOOP:       cls.kind = tomd_pkg::TOMD_K_SNP_SNAP;
          tomd_pkg::OPC_CODE_SNOOP:           cls.kind = tomd_pkg::TOMD_K_SNP_CODE;
          tomd_pkg::OPC_DATA_SNOOP:           cls.kind = tomd_pkg::TOMD_K_SNP_DATA;
          tomd_pkg::OPC_MIGRATORY_DATA_SNOOP: cls.kind = tomd_pkg::TOMD_K_SNP_MIG;
          tomd_pkg::OPC_INVALIDATE_OWN_SNOOP: cls.kind = tomd_pkg::TOMD_K_SNP_IOWN;
          tomd_pkg::OPC_INVALIDATE_SNOOP:     cls.kind = tomd_pkg::TOMD_K_SNP_INV;
          default:                            cls.kind = tomd_pkg::TOMD_K_NONE;
        endcase
      end
      tomd_pkg::TOMD_Q_RMT: begin
        unique case (cls.opcode)
          tomd_pkg::OPC_SNAPSHOT_READ:       cls.kind = tomd_pkg::TOMD_K_RD_SNAP;
          tomd_pkg::OPC_CODE_READ:           cls.kind = tomd_pkg::TOMD_K_RD_CODE;
          tomd_pkg::OPC_DATA_READ:           cls.kind = tomd_pkg::TOMD_K_RD_DATA;
          tomd_pkg::OPC_MIGRATORY_DATA_READ: cls.kind = tomd_pkg::TOMD_K_RD_MIG;
          tomd_pkg::OPC_READ_INVALIDATE_OWN: cls.kind = tomd_pkg::TOMD_K_RD_IOWN;
          tomd_pkg::OPC_READ_INV_X_TO_I:     cls.kind = tomd_pkg::TOMD_K_RD_XTOI;
          tomd_pkg::OPC_READ_PUSH_HINT:      cls.kind = tomd_pkg::TOMD_K_RD_PUSH;
          tomd_pkg::OPC_READ_INV_I_TO_E:     cls.kind = tomd_pkg::TOMD_K_RD_ITOE;
          tomd_pkg::OPC_READ_INVALIDATE:     cls.kind = tomd_pkg::TOMD_K_RD_INV;
          default:                           cls.kind = tomd_pkg::TOMD_K_NONE;
        endcase
      end
      tomd_pkg::TOMD_Q_WB: begin
        unique case (cls.opcode)
          tomd_pkg::OPC_WRITEBACK_MODIFIED_INVALIDATE: cls.kind = tomd_pkg::TOMD_K_WB_M_I;
          tomd_pkg::OPC_WRITEBACK_MODIFIED_SHARED:     cls.kind = tomd_pkg::TOMD_K_WB_M_S;
          tomd_pkg::OPC_WRITEBACK_MODIFIED_EXCLUSIVE:  cls.kind = tomd_pkg::TOMD_K_WB_M_EQ;
          tomd_pkg::OPC_NONSNOOP_WRITE:                cls.kind = tomd_pkg::TOMD_K_NS_WR;
          tomd_pkg::OPC_PARTIAL_WRITEBACK_INVALIDATE:  cls.kind = tomd_pkg::TOMD_K_PWB_M_I;
          default:                                     cls.kind = tomd_pkg::TOMD_K_NONE;
        endcase
      end
    endcase
  end

endmodule // tomd_classify

`default_nettype wire

// ===== tomd_if.sv
`timescale 1ns/1ps
`default_nettype none

// pairs one opcode with its queue class and carries the classification back
interface tomd_class_if;
  tomd_pkg::tomd_queue_t queue;
  logic [11:0]           opcode;
  tomd_pkg::tomd_kind_t  kind;

  modport requester (output queue, output opcode, input kind);
  modport classifier (input queue, input opcode, output kind);
endinterface

`default_nettype wire

// ===== tomd_pkg.sv
`default_nettype none

package tomd_pkg;

  // opcode-match value width: queue class is carried apart from the value, value is 12 bits
  localparam int OPC_W = 12;

  // queue class codes carried by tracker entries
  typedef enum logic [1:0] {
    TOMD_Q_CORE  = 2'b00,
    TOMD_Q_PROBE = 2'b01,
    TOMD_Q_RMT   = 2'b10,
    TOMD_Q_WB    = 2'b11
  } tomd_queue_t;

  // core-request queue class values
  localparam logic [11:0] OPC_WRITEBACK_MODIFIED_KEEP_EXCLUSIVE = 12'h245;
  localparam logic [11:0] OPC_CLEAN_WRITEBACK_DROP              = 12'h246;
  localparam logic [11:0] OPC_CLEAN_WRITEBACK_KEEP              = 12'h247;
  localparam logic [11:0] OPC_INVALIDATE_FOR_OWNERSHIP          = 12'h248;
  localparam logic [11:0] OPC_PREFETCH_OWNERSHIP_READ           = 12'h258;
  localparam logic [11:0] OPC_PREFETCH_CODE_READ                = 12'h259;
  localparam logic [11:0] OPC_PREFETCH_DATA_READ                = 12'h25A;
  localparam logic [11:0] OPC_LOGICAL_INTERRUPT                 = 12'h279;
  localparam logic [11:0] OPC_PHYSICAL_INTERRUPT                = 12'h27A;
  localparam logic [11:0] OPC_INTERRUPT_PRIORITY_UPDATE         = 12'h27B;
  localparam logic [11:0] OPC_SPLIT_LOCK_START                  = 12'h27E;
  localparam logic [11:0] OPC_LOCK_START                        = 12'h27F;
  // probe queue values
  localparam logic [11:0] OPC_SNAPSHOT_SNOOP                    = 12'h180;
  localparam logic [11:0] OPC_CODE_SNOOP                        = 12'h181;
  localparam logic [11:0] OPC_DATA_SNOOP                        = 12'h182;
  localparam logic [11:0] OPC_MIGRATORY_DATA_SNOOP              = 12'h183;
  localparam logic [11:0] OPC_INVALIDATE_OWN_SNOOP              = 12'h184;
  localparam logic [11:0] OPC_INVALIDATE_SNOOP                  = 12'h185;
  // remote request queue values
  localparam logic [11:0] OPC_SNAPSHOT_READ                     = 12'h080;
  localparam logic [11:0] OPC_CODE_READ                         = 12'h081;
  localparam logic [11:0] OPC_DATA_READ                         = 12'h082;
  localparam logic [11:0] OPC_MIGRATORY_DATA_READ               = 12'h083;
  localparam logic [11:0] OPC_READ_INVALIDATE_OWN               = 12'h084;
  localparam logic [11:0] OPC_READ_INV_X_TO_I                   = 12'h085;
  localparam logic [11:0] OPC_READ_PUSH_HINT                    = 12'h086;
  localparam logic [11:0] OPC_READ_INV_I_TO_E                   = 12'h087;
  localparam logic [11:0] OPC_READ_INVALIDATE                   = 12'h08C;
  // writeback queue values
  localparam logic [11:0] OPC_WRITEBACK_MODIFIED_INVALIDATE     = 12'h000;
  localparam logic [11:0] OPC_WRITEBACK_MODIFIED_SHARED         = 12'h001;
  localparam logic [11:0] OPC_WRITEBACK_MODIFIED_EXCLUSIVE      = 12'h002;
  localparam logic [11:0] OPC_NONSNOOP_WRITE                    = 12'h003;
  localparam logic [11:0] OPC_PARTIAL_WRITEBACK_INVALIDATE      = 12'h004;

  // decoded opcode meaning
  typedef enum logic [5:0] {
    TOMD_K_NONE     = 6'h00,
    TOMD_K_WB_M_E   = 6'h01,
    TOMD_K_CWB_DROP = 6'h02,
    TOMD_K_CWB_KEEP = 6'h03,
    TOMD_K_INV_OWN  = 6'h04,
    TOMD_K_PF_OWN   = 6'h05,
    TOMD_K_PF_CODE  = 6'h06,
    TOMD_K_PF_DATA  = 6'h07,
    TOMD_K_INT_LOG  = 6'h08,
    TOMD_K_INT_PHY  = 6'h09,
    TOMD_K_INT_PRI  = 6'h0A,
    TOMD_K_SPLITLK  = 6'h0B,
    TOMD_K_LOCK     = 6'h0C,
    TOMD_K_SNP_SNAP = 6'h0D,
    TOMD_K_SNP_CODE = 6'h0E,
    TOMD_K_SNP_DATA = 6'h0F,
    TOMD_K_SNP_MIG  = 6'h10,
    TOMD_K_SNP_IOWN = 6'h11,
    TOMD_K_SNP_INV  = 6'h12,
    TOMD_K_RD_SNAP  = 6'h13,
    TOMD_K_RD_CODE  = 6'h14,
    TOMD_K_RD_DATA  = 6'h15,
    TOMD_K_RD_MIG   = 6'h16,
    TOMD_K_RD_IOWN  = 6'h17,
    TOMD_K_RD_XTOI  = 6'h18,
    TOMD_K_RD_PUSH  = 6'h19,
    TOMD_K_RD_ITOE  = 6'h1A,
    TOMD_K_RD_INV   = 6'h1B,
    TOMD_K_WB_M_I   = 6'h1C,
    TOMD_K_WB_M_S   = 6'h1D,
    TOMD_K_WB_M_EQ  = 6'h1E,
    TOMD_K_NS_WR    = 6'h1F,
    TOMD_K_PWB_M_I  = 6'h20
  } tomd_kind_t;

  // coherence outcome hints
  typedef enum logic [2:0] {
    TOMD_ST_NONE      = 3'b000,
    TOMD_ST_INVALID   = 3'b001,
    TOMD_ST_SHARED    = 3'b010,
    TOMD_ST_EXCLUSIVE = 3'b011,
    TOMD_ST_MODIFIED  = 3'b100,
    TOMD_ST_UNCHANGED = 3'b101
  } tomd_state_t;

  // reset values
  localparam logic [11:0] FILTER_RST = 12'h000;

endpackage

`default_nettype wire

// ===== tomd_top.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 0x245 core class: modified writeback, keep exclusive
// - 0x246: clean writeback, ownership dropped
// - 0x247: clean writeback, ownership may stay
// - 0x248: invalidate line for exclusive ownership
// - 0x258-0x25A: prefetches; miss starts ownership/code/data read
// - 0x279-0x27B: logical, physical interrupt, priority update
// - 0x27E split-lock start, 0x27F lock start
// - probe 0x180-0x185: six snoop kinds in order
// - data snoop exclusive only if all invalid
// - remote 0x080-0x087 read family, 0x080 snapshot
// - data read grants shared or exclusive
// - migratory read may forward modified, no writeback
// - read-invalidate-own: modified if forwarded, else exclusive
// - 0x08C read invalidate, exclusive from home
// - writeback 0x000 modified line, invalidate
// - writeback 0x001 modified line, leave shared
// - writeback 0x002 modified eviction, leave exclusive
// - writeback 0x003 non-snooping write, no state change
// - writeback 0x004 partial masked write, invalidate
// - two match fields, results ORed
module tomd_top (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // filter settings, held by software-side logic on this clock
  input  wire logic [11:0]           filter_opcode_match_field_a,
  input  wire logic [11:0]           filter_opcode_match_field_b,
  // tracker entry presented for matching
  input  wire logic                  entry_valid,
  input  wire tomd_pkg::tomd_queue_t entry_queue,
  input  wire logic [11:0]           entry_opcode,
  // coherence side information for the entry
  input  wire logic                  all_invalid_response,
  input  wire logic                  peer_holds_shared,
  input  wire logic                  peer_forwarded_modified,
  input  wire logic                  prefetch_hit,
  // results
  output var  logic                  match_any,
  output var  logic                  match_a,
  output var  logic                  match_b,
  output var  tomd_pkg::tomd_kind_t  entry_kind,
  output var  tomd_pkg::tomd_state_t granted_state,
  output var  logic                  replacement_update,
  output var  logic                  launch_ownership_read,
  output var  logic                  launch_code_read,
  output var  logic                  launch_data_read,
  output var  logic                  commit_before_data,
  output var  logic                  byte_mask_used
);

  // state of the block
  typedef struct packed {
    logic                  match_any;
    logic                  match_a;
    logic                  match_b;
    tomd_pkg::tomd_kind_t  kind;
    tomd_pkg::tomd_state_t state;
    logic                  repl;
    logic                  l_own;
    logic                  l_code;
    logic                  l_data;
    logic                  commit;
    logic                  mask;
  } tomd_st_t;

  tomd_st_t st_r;
  tomd_st_t st_nxt;

  tomd_class_if cls ();

  // exact match of a field against the entry's opcode, only when class and opcode decode to a kind
  function automatic logic field_hit(input logic [11:0] fld, input tomd_pkg::tomd_kind_t k,
                                     input logic [11:0] opc);
    field_hit = (k != tomd_pkg::TOMD_K_NONE) && (fld == opc);
  endfunction

  // classifier sees the entry directly
  assign cls.queue  = entry_queue;
  assign cls.opcode = entry_opcode;

  tomd_classify u_classify (
    .cls (cls)
  );

  // next-state: match and coherence meaning of the entry
  always_comb begin
    st_nxt        = '0;
    st_nxt.kind   = tomd_pkg::TOMD_K_NONE;
    st_nxt.state  = tomd_pkg::TOMD_ST_NONE;
    if (entry_valid) begin
      st_nxt.kind      = cls.kind;
      st_nxt.match_a   = field_hit(filter_opcode_match_field_a, cls.kind, entry_opcode);
      st_nxt.match_b   = field_hit(filter_opcode_match_field_b, cls.kind, entry_opcode);
      st_nxt.match_any = st_nxt.match_a | st_nxt.match_b;
      unique case (cls.kind)
        tomd_pkg::TOMD_K_WB_M_E:   st_nxt.state = tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_CWB_DROP: st_nxt.state = tomd_pkg::TOMD_ST_INVALID;
        tomd_pkg::TOMD_K_CWB_KEEP: st_nxt.state = tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_INV_OWN:  st_nxt.state = tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_PF_OWN: begin
          st_nxt.repl  = prefetch_hit;
          st_nxt.l_own = !prefetch_hit;
        end
        tomd_pkg::TOMD_K_PF_CODE: begin
          st_nxt.repl   = prefetch_hit;
          st_nxt.l_code = !prefetch_hit;
        end
        tomd_pkg::TOMD_K_PF_DATA: begin
          st_nxt.repl   = prefetch_hit;
          st_nxt.l_data = !prefetch_hit;
        end
        tomd_pkg::TOMD_K_SNP_DATA:
          st_nxt.state = all_invalid_response ? tomd_pkg::TOMD_ST_EXCLUSIVE
                                              : tomd_pkg::TOMD_ST_SHARED;
        tomd_pkg::TOMD_K_SNP_CODE: st_nxt.state = tomd_pkg::TOMD_ST_SHARED;
        tomd_pkg::TOMD_K_SNP_INV:  st_nxt.state = tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_RD_SNAP:  st_nxt.state = tomd_pkg::TOMD_ST_INVALID;
        tomd_pkg::TOMD_K_RD_CODE:  st_nxt.state = tomd_pkg::TOMD_ST_SHARED;
        tomd_pkg::TOMD_K_RD_DATA:
          st_nxt.state = peer_holds_shared ? tomd_pkg::TOMD_ST_SHARED
                                           : tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_RD_MIG:
          st_nxt.state = peer_forwarded_modified ? tomd_pkg::TOMD_ST_MODIFIED
                       : (peer_holds_shared ? tomd_pkg::TOMD_ST_SHARED : tomd_pkg::TOMD_ST_EXCLUSIVE);
        tomd_pkg::TOMD_K_RD_IOWN:
          st_nxt.state = peer_forwarded_modified ? tomd_pkg::TOMD_ST_MODIFIED
                                                 : tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_RD_INV: begin
          st_nxt.state  = tomd_pkg::TOMD_ST_EXCLUSIVE;
          st_nxt.commit = 1'b1;
        end
        tomd_pkg::TOMD_K_WB_M_I:  st_nxt.state = tomd_pkg::TOMD_ST_INVALID;
        tomd_pkg::TOMD_K_WB_M_S:  st_nxt.state = tomd_pkg::TOMD_ST_SHARED;
        tomd_pkg::TOMD_K_WB_M_EQ: st_nxt.state = tomd_pkg::TOMD_ST_EXCLUSIVE;
        tomd_pkg::TOMD_K_NS_WR:   st_nxt.state = tomd_pkg::TOMD_ST_UNCHANGED;
        tomd_pkg::TOMD_K_PWB_M_I: begin
          st_nxt.state = tomd_pkg::TOMD_ST_INVALID;
          st_nxt.mask  = 1'b1;
        end
        default: st_nxt.state = tomd_pkg::TOMD_ST_NONE;
      endcase
    end
  end

  // register the state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_r       <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign match_any             = st_r.match_any;
  assign match_a               = st_r.match_a;
  assign match_b               = st_r.match_b;
  assign entry_kind            = st_r.kind;
  assign granted_state         = st_r.state;
  assign replacement_update    = st_r.repl;
  assign launch_ownership_read = st_r.l_own;
  assign launch_code_read      = st_r.l_code;
  assign launch_data_read      = st_r.l_data;
  assign commit_before_data    = st_r.commit;
  assign byte_mask_used        = st_r.mask;

endmodule // tomd_top

`default_nettype wire

// ===== tomd_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ties each result except launch_code_read and launch_data_read to the entry sampled one edge earlier
module tomd_top_properties (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  resetn,
  // filter and entry
  input wire logic [11:0]           filter_opcode_match_field_a,
  input wire logic [11:0]           filter_opcode_match_field_b,
  input wire logic                  entry_valid,
  input wire tomd_pkg::tomd_queue_t entry_queue,
  input wire logic [11:0]           entry_opcode,
  input wire logic                  all_invalid_response,
  input wire logic                  peer_holds_shared,
  input wire logic                  peer_forwarded_modified,
  input wire logic                  prefetch_hit,
  // results
  input wire logic                  match_any,
  input wire logic                  match_a,
  input wire logic                  match_b,
  input wire tomd_pkg::tomd_kind_t  entry_kind,
  input wire tomd_pkg::tomd_state_t granted_state,
  input wire logic                  replacement_update,
  input wire logic                  launch_ownership_read,
  input wire logic                  launch_code_read,
  input wire logic                  launch_data_read,
  input wire logic                  commit_before_data,
  input wire logic                  byte_mask_used
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // valid, class and value in one word: core 4xxx, probe 5xxx, remote 6xxx, writeback 7xxx
  logic [14:0] key;
  assign key = {entry_valid, entry_queue, entry_opcode};

  property p_or; match_any == (match_a | match_b); endproperty
  a_or: assert property (p_or) else $error("match_any differs from either field result");
  property p_a; match_a |-> $past(entry_valid) && $past(entry_opcode) == $past(filter_opcode_match_field_a); endproperty
  a_a: assert property (p_a) else $error("field a match without equal value");
  property p_b; match_b |-> $past(entry_valid) && $past(entry_opcode) == $past(filter_opcode_match_field_b); endproperty
  a_b: assert property (p_b) else $error("field b match without equal value");
  property p_idle; !entry_valid |=> !match_any && entry_kind == tomd_pkg::TOMD_K_NONE; endproperty
  a_idle: assert property (p_idle) else $error("result seen for an empty cycle");
  property p_wbme; key == 15'h4245 |=> entry_kind == tomd_pkg::TOMD_K_WB_M_E; endproperty
  a_wbme: assert property (p_wbme) else $error("modified writeback keep exclusive not decoded");
  property p_snp;
    key inside {[15'h5180:15'h5185]} |=> entry_kind == tomd_pkg::tomd_kind_t'(6'h0D + 6'($past(entry_opcode) - 12'h180));
  endproperty
  a_snp: assert property (p_snp) else $error("snoop kinds out of order");
  property p_sdat; key == 15'h5182 |=> granted_state == ($past(all_invalid_response) ? 3'h3 : 3'h2); endproperty
  a_sdat: assert property (p_sdat) else $error("data snoop state wrong");
  property p_rdat; key == 15'h6082 |=> granted_state == ($past(peer_holds_shared) ? 3'h2 : 3'h3); endproperty
  a_rdat: assert property (p_rdat) else $error("data read state wrong");
  property p_iown; key == 15'h6084 |=> granted_state == ($past(peer_forwarded_modified) ? 3'h4 : 3'h3); endproperty
  a_iown: assert property (p_iown) else $error("read invalidate own state wrong");
  property p_pf;
    key == 15'h4258 |=> replacement_update == $past(prefetch_hit) && launch_ownership_read == !$past(prefetch_hit);
  endproperty
  a_pf: assert property (p_pf) else $error("ownership prefetch hit or miss action wrong");
  property p_rinv; key == 15'h608C |=> commit_before_data && entry_kind == tomd_pkg::TOMD_K_RD_INV; endproperty
  a_rinv: assert property (p_rinv) else $error("read invalidate without commit");
  property p_mask; key == 15'h7004 |=> byte_mask_used && granted_state == tomd_pkg::TOMD_ST_INVALID; endproperty
  a_mask: assert property (p_mask) else $error("partial writeback not masked");
endmodule // tomd_top_properties

bind tomd_top tomd_top_properties i_tomd_top_properties (.*);

`default_nettype wire

// ===== tomd_tracker_model.sv
`timescale 1ns/1ps
`default_nettype none

// stands in for the tracker: places one entry per cycle on the decoder inputs
module tomd_tracker_model (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // entry requested by the bench, side bits {invalid, shared, forwarded, hit}
  input  wire logic                  m_valid,
  input  wire tomd_pkg::tomd_queue_t m_queue,
  input  wire logic [11:0]           m_opcode,
  input  wire logic [3:0]            m_side,
  // entry shown to the decoder
  output var  logic                  entry_valid,
  output var  tomd_pkg::tomd_queue_t entry_queue,
  output var  logic [11:0]           entry_opcode,
  output var  logic                  all_invalid_response,
  output var  logic                  peer_holds_shared,
  output var  logic                  peer_forwarded_modified,
  output var  logic                  prefetch_hit
);
  // idle cycles flip the old opcode and side bits so stale values never look valid
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      entry_valid <= 1'b0;
      entry_queue <= tomd_pkg::TOMD_Q_CORE;
      entry_opcode <= 12'h000;
      {all_invalid_response, peer_holds_shared, peer_forwarded_modified, prefetch_hit} <= 4'h0;
    end else begin
      entry_valid <= m_valid;
      entry_queue <= m_queue;
      entry_opcode <= m_valid ? m_opcode : ~entry_opcode;
      {all_invalid_response, peer_holds_shared, peer_forwarded_modified, prefetch_hit} <=
        m_valid ? m_side : ~{all_invalid_response, peer_holds_shared, peer_forwarded_modified, prefetch_hit};
    end
  end
endmodule // tomd_tracker_model

`default_nettype wire
